// [design/ssq_status_core.v]
`timescale 1ns/10ps
`include "ssq_regs.vh"
`default_nettype none
module ssq_status_core (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // query and command port
    input  wire        cmd_valid,
    input  wire        cmd_write,
    input  wire        cmd_bit_mode,
    input  wire [2:0]  cmd_bit,
    input  wire [3:0]  cmd_sel,
    input  wire [7:0]  cmd_wdata,
    input  wire        cmd_clear_status,
    output reg  [7:0]  rsp_data,
    output reg         rsp_valid,
    output reg         rsp_is_keyword,
    // terminator sequence for the response formatter
    output wire [1:0]  term_len,
    output wire [7:0]  term_char0,
    output wire [7:0]  term_char1,
    // event sources, one-cycle pulses from the same clock
    input  wire [7:0]  std_event_set,
    input  wire [7:0]  comm_error_set,
    input  wire        button_press,
    input  wire [3:0]  button_channel,
    // asynchronous level inputs
    input  wire [4:0]  overload_in,
    input  wire        input_buffer_empty,
    input  wire        parser_idle,
    // state
    output wire [7:0]  status_summary_byte,
    output wire        keyword_response_mode,
    output reg         status_n
);
    reg  [4:0] ov_s1_reg;
    reg  [4:0] overload_condition_reg;
    reg  [1:0] idle_s1_reg;
    reg  [1:0] idle_s2_reg;
    reg  [4:0] ov_prev_reg;
    reg  [4:0] overload_event_reg;
    reg  [7:0] std_event_reg;
    reg  [7:0] comm_error_event_reg;
    reg  [4:0] ov_enable_reg;
    reg  [7:0] std_enable_reg;
    reg  [7:0] comm_enable_reg;
    reg  [7:0] service_request_mask;
    reg  [3:0] last_button_query;
    reg        token_reg;
    reg  [2:0] term_reg;
    reg  [7:0] srq_prev_reg;
    reg  [7:0] rdata_next;
    reg        kw_next;
    wire       rd;
    wire       wr;
    wire [7:0] bit_sel;
    wire [7:0] clr_mask;
    wire       overload_summary_bit;
    wire       std_event_summary_bit;
    wire       comm_error_summary_bit;
    wire       master_summary_bit;
    wire       idle_bit;
    wire [7:0] stb_low;
    wire [7:0] srq_now;
    wire       new_srq;

    assign rd = cmd_valid & ~cmd_write;
    assign wr = cmd_valid & cmd_write;
    assign bit_sel  = 8'h01 << cmd_bit;
    assign clr_mask = cmd_bit_mode ? bit_sel : 8'hff;

    // input synchronisers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ov_s1_reg              <= 5'h00;
            overload_condition_reg <= 5'h00;
            idle_s1_reg            <= 2'h0;
            idle_s2_reg            <= 2'h0;
        end else begin
            ov_s1_reg              <= overload_in;
            overload_condition_reg <= ov_s1_reg;
            idle_s1_reg            <= {input_buffer_empty, parser_idle};
            idle_s2_reg            <= idle_s1_reg;
        end
    end

    // summaries
    assign overload_summary_bit   = |(overload_event_reg & ov_enable_reg);
    assign std_event_summary_bit  = |(std_event_reg & std_enable_reg);
    assign comm_error_summary_bit = |(comm_error_event_reg & comm_enable_reg);
    assign idle_bit = idle_s2_reg[1] & idle_s2_reg[0];
    assign stb_low  = {comm_error_summary_bit, 1'b0, std_event_summary_bit, idle_bit,
                       3'h0, overload_summary_bit};
    assign srq_now  = stb_low & service_request_mask;
    assign master_summary_bit = |srq_now;
    assign status_summary_byte = stb_low | ({7'h00, master_summary_bit} << `SSQ_STB_MSS);
    assign new_srq = |(srq_now & ~srq_prev_reg);
    assign keyword_response_mode = token_reg;

    // event, enable and setting registers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ov_prev_reg          <= 5'h00;
            overload_event_reg   <= 5'h00;
            std_event_reg        <= 8'h00;
            comm_error_event_reg <= 8'h00;
            ov_enable_reg        <= 5'h00;
            std_enable_reg       <= `SSQ_MASK_RST;
            comm_enable_reg      <= `SSQ_MASK_RST;
            service_request_mask <= `SSQ_MASK_RST;
            last_button_query    <= 4'h0;
            token_reg            <= `SSQ_TOKEN_RST;
            term_reg             <= `SSQ_TERM_RST;
            srq_prev_reg         <= 8'h00;
            status_n             <= 1'b1;
        end else begin
            ov_prev_reg <= overload_condition_reg;
            // clear on read first, set wins over clear
            if (cmd_clear_status) begin
                overload_event_reg   <= overload_condition_reg & ~ov_prev_reg;
                std_event_reg        <= std_event_set;
                comm_error_event_reg <= comm_error_set;
            end else begin
                overload_event_reg <= (overload_event_reg
                    & ~((rd && cmd_sel == `SSQ_SEL_OVERLOAD_EVENT_REG) ? clr_mask[4:0] : 5'h00))
                    | (overload_condition_reg & ~ov_prev_reg);
                std_event_reg <= (std_event_reg
                    & ~((rd && cmd_sel == `SSQ_SEL_ESR) ? clr_mask : 8'h00))
                    | std_event_set;
                comm_error_event_reg <= (comm_error_event_reg
                    & ~((rd && cmd_sel == `SSQ_SEL_COMM_ERROR_EVENT_REG) ? clr_mask : 8'h00))
                    | comm_error_set;
            end
            if (button_press)
                last_button_query <= button_channel;
            else if (rd && cmd_sel == `SSQ_SEL_BTN)
                last_button_query <= 4'h0;
            if (wr) begin
                case (cmd_sel)
                    `SSQ_SEL_SRE:   service_request_mask <= cmd_wdata & 8'hbf;
                    `SSQ_SEL_ESE:   std_enable_reg <= cmd_wdata;
                    `SSQ_SEL_CESE:  comm_enable_reg <= cmd_wdata;
                    `SSQ_SEL_OVSE:  ov_enable_reg <= cmd_wdata[4:0];
                    `SSQ_SEL_TOKEN: token_reg <= cmd_wdata[0];
                    `SSQ_SEL_TERM: begin
                        if (cmd_wdata[2:0] <= `SSQ_TERM_MAX && cmd_wdata[7:3] == 5'h00)
                            term_reg <= cmd_wdata[2:0];
                    end
                    default: begin
                    end
                endcase
            end
            // status line: set on new condition, released by status byte query
            srq_prev_reg <= srq_now;
            if (new_srq)
                status_n <= 1'b0;
            else if (rd && cmd_sel == `SSQ_SEL_STB)
                status_n <= 1'b1;
        end
    end

    // response mux
    always @* begin
        rdata_next = 8'h00;
        kw_next    = 1'b0;
        case (cmd_sel)
            `SSQ_SEL_STB:   rdata_next = status_summary_byte;
            `SSQ_SEL_SRE:   rdata_next = service_request_mask;
            `SSQ_SEL_ESR:   rdata_next = std_event_reg;
            `SSQ_SEL_ESE:   rdata_next = std_enable_reg;
            `SSQ_SEL_COMM_ERROR_EVENT_REG:  rdata_next = comm_error_event_reg;
            `SSQ_SEL_CESE:  rdata_next = comm_enable_reg;
            `SSQ_SEL_OVERLOAD_CONDITION_REG:  rdata_next = {3'h0, overload_condition_reg};
            `SSQ_SEL_OVERLOAD_EVENT_REG:  rdata_next = {3'h0, overload_event_reg};
            `SSQ_SEL_OVSE:  rdata_next = {3'h0, ov_enable_reg};
            `SSQ_SEL_BTN:   rdata_next = {4'h0, last_button_query};
            `SSQ_SEL_TOKEN: begin
                rdata_next = {7'h00, token_reg};
                kw_next    = token_reg;
            end
            `SSQ_SEL_TERM: begin
                rdata_next = {5'h00, term_reg};
                kw_next    = token_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
        if (cmd_bit_mode)
            rdata_next = {7'h00, |(rdata_next & bit_sel)};
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_data       <= 8'h00;
            rsp_valid      <= 1'b0;
            rsp_is_keyword <= 1'b0;
        end else begin
            rsp_valid      <= rd;
            rsp_data       <= rd ? rdata_next : rsp_data;
            rsp_is_keyword <= rd ? kw_next : rsp_is_keyword;
        end
    end

    ssq_term_gen u_term (
        .term_sel   (term_reg),
        .term_len   (term_len),
        .term_char0 (term_char0),
        .term_char1 (term_char1)
    );
endmodule // ssq_status_core
`default_nettype wire

// [design/ssq_term_gen.v]
`timescale 1ns/10ps
`include "ssq_regs.vh"
`default_nettype none
// terminator character sequence for a selection code
module ssq_term_gen (
    // selection
    input  wire [2:0]  term_sel,
    // sequence
    output reg  [1:0]  term_len,
    output reg  [7:0]  term_char0,
    output reg  [7:0]  term_char1
);
    always @* begin
        term_len   = 2'h0;
        term_char0 = 8'h00;
        term_char1 = 8'h00;
        case (term_sel)
            `SSQ_TERM_CR: begin
                term_len   = 2'h1;
                term_char0 = `SSQ_CHAR_CR;
            end
            `SSQ_TERM_LF: begin
                term_len   = 2'h1;
                term_char0 = `SSQ_CHAR_LF;
            end
            `SSQ_TERM_RETURN_THEN_LINEFEED: begin
                term_len   = 2'h2;
                term_char0 = `SSQ_CHAR_CR;
                term_char1 = `SSQ_CHAR_LF;
            end
            `SSQ_TERM_LINEFEED_THEN_RETURN: begin
                term_len   = 2'h2;
                term_char0 = `SSQ_CHAR_LF;
                term_char1 = `SSQ_CHAR_CR;
            end
            default: begin
                term_len   = 2'h0;
            end
        endcase
    end
endmodule // ssq_term_gen
`default_nettype wire

// [dv/ssq_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ssq_host_model (
    // clock
    input  wire logic       ref_clk,
    // command port
    output var  logic       cmd_valid,
    output var  logic       cmd_write,
    output var  logic       cmd_bit_mode,
    output var  logic [2:0] cmd_bit,
    output var  logic [3:0] cmd_sel,
    output var  logic [7:0] cmd_wdata,
    // response
    input  wire logic [7:0] rsp_data,
    input  wire logic       rsp_valid
);
    logic rv;
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_bit_mode = 1'b0;
        cmd_bit = 3'h0;
        cmd_sel = 4'h0;
        cmd_wdata = 8'h00;
    end
    // one command per call; a status byte query also releases the line
    task xfer(input logic w, input logic [3:0] s, input logic bm, input logic [2:0] b,
              input logic [7:0] d);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_bit_mode <= bm;
        cmd_bit <= b;
        cmd_sel <= s;
        cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
        rv = rsp_valid;
    endtask
endmodule // ssq_host_model
`default_nettype wire

// [dv/ssq_status_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module ssq_status_checker (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // command port
    input  wire logic       cmd_valid,
    input  wire logic       cmd_write,
    input  wire logic [3:0] cmd_sel,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       rsp_valid,
    // status and settings
    input  wire logic [1:0] term_len,
    input  wire logic [7:0] term_char0,
    input  wire logic [7:0] term_char1,
    input  wire logic       input_buffer_empty,
    input  wire logic       parser_idle,
    input  wire logic [7:0] status_summary_byte,
    input  wire logic       keyword_response_mode,
    input  wire logic       status_n
);
    logic [7:0] mask_reg;
    wire  [7:0] en  = status_summary_byte & mask_reg & 8'hbf;
    wire        wr  = cmd_valid & cmd_write;
    wire        qry = cmd_valid & ~cmd_write;
    // shadow of the service mask
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= 8'h00;
        end else if (wr && cmd_sel == 4'h1) begin
            mask_reg <= cmd_wdata;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    rsp_once_a: assert property (rsp_valid == $past(qry))
        else $error("response strobe wrong");
    token_wr_a: assert property (wr && cmd_sel == 4'ha |=>
        keyword_response_mode == $past(cmd_wdata[0])) else $error("token mode wrong");
    term_rst_a: assert property (disable iff (1'b0) !rst_n |-> term_len == 2'h2 &&
        term_char0 == 8'h0d && term_char1 == 8'h0a) else $error("reset terminator wrong");
    term_cr_a: assert property (wr && cmd_sel == 4'hb && cmd_wdata == 8'h01 |=>
        term_len == 2'h1 && term_char0 == 8'h0d) else $error("cr terminator wrong");
    bits_zero_a: assert property (status_summary_byte[3:1] == 3'h0)
        else $error("undefined status bits set");
    idle_src_a: assert property (status_summary_byte[4] |->
        $past(input_buffer_empty, 2) && $past(parser_idle, 2)) else $error("idle bit wrong");
    mss_sum_a: assert property (status_summary_byte[6] == (|en))
        else $error("master summary wrong");
    line_set_a: assert property ((en & ~$past(en)) != 8'h00 |=> !status_n)
        else $error("status line not asserted");
    line_hold_a: assert property (status_n && (en & ~$past(en)) == 8'h00 |=> status_n)
        else $error("status line reasserted");
    stb_rel_a: assert property (qry && cmd_sel == 4'h0 && (en & ~$past(en)) == 8'h00 |=>
        status_n) else $error("status line not released");
    cover property (rsp_valid && keyword_response_mode);
    cover property (!status_n);
    cover property (qry && cmd_sel == 4'h0 && !status_n);
endmodule // ssq_status_checker
bind ssq_status_core ssq_status_checker i_ssq_status_checker (.*);
`default_nettype wire

// [dv/status_summary_and_query_config_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %0t: got %h want %h", $time, a, e); end end
module status_summary_and_query_config_bench;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b1;
    logic        cmd_valid, cmd_write, cmd_bit_mode, rsp_valid, rsp_is_keyword;
    logic        cmd_clear_status = 1'b0, button_press = 1'b0, keyword_response_mode, status_n;
    logic        input_buffer_empty = 1'b1, parser_idle = 1'b1;
    logic [2:0]  cmd_bit;
    logic [3:0]  cmd_sel, button_channel = 4'h0;
    logic [7:0]  cmd_wdata, rsp_data, term_char0, term_char1, status_summary_byte;
    logic [7:0]  std_event_set = 8'h00, comm_error_set = 8'h00;
    logic [1:0]  term_len;
    logic [4:0]  overload_in = 5'h00;
    logic [17:0] tt[5] = '{18'h00000, 18'h10d00, 18'h10a00, 18'h20d0a, 18'h20a0d};
    int          num_errors = 0, n_checks = 0, k;
    always #5 ref_clk = ~ref_clk;
    ssq_status_core i_ssq_status_core (.*);
    ssq_host_model i_ssq_host_model (.*);
    task q(input logic [3:0] s, input logic [7:0] e);
        i_ssq_host_model.xfer(1'b0, s, 1'b0, 3'h0, 8'h00);
        `CHK(i_ssq_host_model.rv, 1'b1)
        `CHK(rsp_data, e)
    endtask
    task w(input logic [3:0] s, input logic [7:0] d);
        i_ssq_host_model.xfer(1'b1, s, 1'b0, 3'h0, d);
        `CHK(i_ssq_host_model.rv, 1'b0)
    endtask
    // one-cycle event pulses, then one edge for the status line
    task ev(input logic [7:0] s, input logic [7:0] c, input logic cl, input logic bp);
        @(posedge ref_clk);
        std_event_set <= s;
        comm_error_set <= c;
        cmd_clear_status <= cl;
        button_press <= bp;
        button_channel <= 4'h6;
        @(posedge ref_clk);
        std_event_set <= 8'h00;
        comm_error_set <= 8'h00;
        cmd_clear_status <= 1'b0;
        button_press <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #1 rst_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        `CHK({term_len, term_char0, term_char1}, 18'h20d0a)
        q(4'hb, 8'h03);
        q(4'ha, 8'h00);
        `CHK(rsp_is_keyword, 1'b0)
        w(4'ha, 8'h01);
        q(4'ha, 8'h01);
        `CHK(rsp_is_keyword, 1'b1)
        `CHK(keyword_response_mode, 1'b1)
        q(4'hb, 8'h03);
        `CHK(rsp_is_keyword, 1'b1)
        w(4'ha, 8'h00);
        for (k = 0; k < 5; k++) begin
            w(4'hb, k[7:0]);
            `CHK({term_len, term_char0, term_char1}, tt[k])
        end
        w(4'hb, 8'h05);
        `CHK({term_len, term_char0, term_char1}, tt[4])
        w(4'hb, 8'h03);
        ev(8'h00, 8'h00, 1'b0, 1'b1);
        q(4'h9, 8'h06);
        q(4'h9, 8'h00);
        w(4'h3, 8'h04);
        w(4'h1, 8'hff);
        q(4'h1, 8'hbf);
        ev(8'h05, 8'h00, 1'b0, 1'b0);
        `CHK(status_n, 1'b0)
        `CHK(status_summary_byte, 8'h70)
        q(4'h0, 8'h70);
        `CHK(status_n, 1'b1)
        `CHK(status_summary_byte, 8'h70)
        repeat (3) @(posedge ref_clk);
        `CHK(status_n, 1'b1)
        i_ssq_host_model.xfer(1'b0, 4'h2, 1'b1, 3'h0, 8'h00);
        `CHK(rsp_data, 8'h01)
        q(4'h2, 8'h04);
        q(4'h2, 8'h00);
        `CHK(status_summary_byte, 8'h50)
        `CHK(status_n, 1'b1)
        w(4'h8, 8'h01);
        @(posedge ref_clk);
        overload_in <= 5'h11;
        repeat (6) @(posedge ref_clk);
        `CHK(status_n, 1'b0)
        q(4'h6, 8'h11);
        q(4'h6, 8'h11);
        `CHK(status_summary_byte[0], 1'b1)
        @(posedge ref_clk);
        overload_in <= 5'h00;
        repeat (6) @(posedge ref_clk);
        q(4'h7, 8'h11);
        q(4'h7, 8'h00);
        w(4'h5, 8'h80);
        ev(8'h00, 8'h80, 1'b0, 1'b0);
        `CHK(status_summary_byte, 8'hd0)
        ev(8'h00, 8'h00, 1'b1, 1'b0);
        `CHK(status_summary_byte, 8'h50)
        @(posedge ref_clk);
        parser_idle <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK(status_summary_byte, 8'h00)
        // mid-run reset brings settings back to their power-on values
        w(4'ha, 8'h01);
        w(4'hb, 8'h01);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        `CHK(keyword_response_mode, 1'b0)
        `CHK({term_len, term_char0, term_char1}, 18'h20d0a)
        q(4'h1, 8'h00);
        `CHK(status_n, 1'b1)
        test_done;
    end
endmodule // status_summary_and_query_config_bench
`default_nettype wire

// [include/ssq_regs.vh]
`ifndef SSQ_REGS_VH
`define SSQ_REGS_VH
// register selectors on the query/command port
`define SSQ_SEL_STB      4'h0
`define SSQ_SEL_SRE      4'h1
`define SSQ_SEL_ESR      4'h2
`define SSQ_SEL_ESE      4'h3
`define SSQ_SEL_COMM_ERROR_EVENT_REG     4'h4
`define SSQ_SEL_CESE     4'h5
`define SSQ_SEL_OVERLOAD_CONDITION_REG     4'h6
`define SSQ_SEL_OVERLOAD_EVENT_REG     4'h7
`define SSQ_SEL_OVSE     4'h8
`define SSQ_SEL_BTN      4'h9
`define SSQ_SEL_TOKEN    4'ha
`define SSQ_SEL_TERM     4'hb
// status byte fields
`define SSQ_STB_OVERLOAD_SUMMARY_BIT     0
`define SSQ_STB_IDLE     4
`define SSQ_STB_ESB      5
`define SSQ_STB_MSS      6
`define SSQ_STB_COMM_ERROR_SUMMARY_BIT     7
// field widths
`define SSQ_OV_W         5
`define SSQ_BTN_W        4
// reset values
`define SSQ_TOKEN_RST    1'h0
`define SSQ_TERM_RST     3'h3
`define SSQ_MASK_RST     8'h00
// terminator codes
`define SSQ_TERM_NONE    3'h0
`define SSQ_TERM_CR      3'h1
`define SSQ_TERM_LF      3'h2
`define SSQ_TERM_RETURN_THEN_LINEFEED    3'h3
`define SSQ_TERM_LINEFEED_THEN_RETURN    3'h4
`define SSQ_TERM_MAX     3'h4
`define SSQ_CHAR_CR      8'h0d
`define SSQ_CHAR_LF      8'h0a
`endif
